/* hdl/bwb_pkg.sv */
// bwb_pkg: constants shared by the bus window bridge and its helpers
// assumes one 100 MHz clock; all bus and link inputs already synchronous to it
`default_nettype none
package bwb_pkg;
  localparam logic [1:0]  SPACE_A16      = 2'h0;
  localparam logic [1:0]  SPACE_A24      = 2'h1;
  localparam logic [1:0]  SPACE_A32      = 2'h2;
  localparam logic [1:0]  SPACE_IACK     = 2'h3;
  localparam logic [1:0]  SIZE_D8        = 2'h0;
  localparam logic [1:0]  SIZE_D16       = 2'h1;
  localparam logic [1:0]  SIZE_D32       = 2'h2;
  localparam int          NUM_WIN        = 4;
  localparam int          WIN_CFG        = 3;
  localparam logic [1:0]  CFG_TOP_BITS   = 2'h3;
  localparam logic [31:0] MASK_A16       = 32'h0000FFFF;
  localparam logic [31:0] MASK_A24       = 32'h00FFFFFF;
  localparam logic [31:0] MASK_A32       = 32'hFFFFFFFF;
  localparam logic [5:0]  REG_IRQ_OFS    = 6'h20;
  localparam logic [5:0]  REG_TRIG_OFS   = 6'h22;
  localparam logic [5:0]  REG_SYS_OFS    = 6'h24;
  localparam logic [15:0] IRQ_CFG_RST    = 16'h0000;
  localparam logic [15:0] TRIG_CFG_RST   = 16'h0000;
  localparam logic [15:0] SYS_CFG_RST    = 16'h0000;
  localparam int          ROUTE_DIR_LSB  = 8;
  localparam int          NUM_IRQ        = 7;
  localparam int          NUM_TRIG       = 8;
  localparam int          NUM_SYS        = 3;
  localparam logic [2:0]  CLK_SW_OUT     = 3'h5;
  localparam logic [2:0]  CLK_SW_IN      = 3'h2;
  localparam int          FIFO_DEPTH     = 16;
  localparam int          REQ_W          = 69;
endpackage : bwb_pkg
`default_nettype wire

/* hdl/bwb_window_decode.sv */
// bwb_window_decode: address window match for one bus, one hit bit per window
// assumes address and space stay steady while a cycle is pending
`default_nettype none
module bwb_window_decode (
  input  wire logic [31:0]      addr_in,
  input  wire logic [1:0]       space_in,
  input  wire logic [3:0]       win_en_in,
  input  wire logic [3:0][31:0] win_base_in,
  input  wire logic [3:0][31:0] win_mask_in,
  output logic      [3:0]       hit_out
);
  function automatic logic [31:0] bwb_space_mask(input logic [1:0] sp);
    if (sp == bwb_pkg::SPACE_A16) begin
      return bwb_pkg::MASK_A16;
    end else if (sp == bwb_pkg::SPACE_A24) begin
      return bwb_pkg::MASK_A24;
    end else begin
      return bwb_pkg::MASK_A32;
    end
  endfunction : bwb_space_mask

  logic cfg_region;
  assign cfg_region = (space_in == bwb_pkg::SPACE_A16) &&
                      (addr_in[15:14] == bwb_pkg::CFG_TOP_BITS);

  genvar w;
  generate
    for (w = 0; w < 3; w++) begin : g_space_win
      // the plain A16 window stops short of the configuration block
      assign hit_out[w] = win_en_in[w] && (space_in == 2'(w)) &&
                          (((addr_in ^ win_base_in[w]) & win_mask_in[w] &
                            bwb_space_mask(2'(w))) == 32'h0) &&
                          !(w == 0 && cfg_region);
    end
  endgenerate
  assign hit_out[bwb_pkg::WIN_CFG] = win_en_in[bwb_pkg::WIN_CFG] && cfg_region;
endmodule : bwb_window_decode
`default_nettype wire

/* hdl/bwb_fifo.sv */
// bwb_fifo: flip-flop fifo with valid/ready on both sides
// assumes a single clock; the drain side may stall for as long as it likes
`default_nettype none
module bwb_fifo #(
  parameter int WIDTH = bwb_pkg::REQ_W,
  parameter int DEPTH = bwb_pkg::FIFO_DEPTH
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 count;
  } bwb_fifo_state_type;
  bwb_fifo_state_type s, next_s;
  logic push, pop;

  assign in_ready_out  = (s.count != (AW+1)'(DEPTH));
  assign out_valid_out = (s.count != '0);
  assign out_data_out  = s.mem[s.rd];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_ready_in && out_valid_out;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr] = in_data_in;
      next_s.wr = (s.wr == AW'(DEPTH - 1)) ? '0 : s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = (s.rd == AW'(DEPTH - 1)) ? '0 : s.rd + 1'b1;
    end
    if (push && !pop) begin
      next_s.count = s.count + 1'b1;
    end else if (pop && !push) begin
      next_s.count = s.count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : bwb_fifo
`default_nettype wire

/* hdl/bwb_bridge.sv */
// bwb_bridge: backplane to cable bus window bridge with signal extension link routing
// assumes a requester holds its request level and fields until it sees a one-cycle ack,
// then drops the request; open-drain lines are active low and driven low by oe
`default_nettype none
module bwb_bridge #(
  parameter logic [7:0] LOG_ADDR   = 8'h01,
  parameter int         FIFO_DEPTH = bwb_pkg::FIFO_DEPTH
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             bp_req_in,
  input  wire logic [31:0]      bp_addr_in,
  input  wire logic [1:0]       bp_space_in,
  input  wire logic [1:0]       bp_size_in,
  input  wire logic             bp_write_in,
  input  wire logic [31:0]      bp_wdata_in,
  output logic                  bp_ack_out,
  output logic      [31:0]      bp_rdata_out,
  output logic                  bp_own_req_out,
  input  wire logic             bp_own_grant_in,
  output logic                  bpm_req_out,
  output logic      [31:0]      bpm_addr_out,
  output logic      [1:0]       bpm_space_out,
  output logic      [1:0]       bpm_size_out,
  output logic                  bpm_write_out,
  output logic      [31:0]      bpm_wdata_out,
  input  wire logic             bpm_ack_in,
  input  wire logic [31:0]      bpm_rdata_in,
  output logic                  cb_own_req_out,
  input  wire logic             cb_own_grant_in,
  output logic                  cbm_req_out,
  output logic      [31:0]      cbm_addr_out,
  output logic      [1:0]       cbm_space_out,
  output logic      [1:0]       cbm_size_out,
  output logic                  cbm_write_out,
  output logic      [31:0]      cbm_wdata_out,
  input  wire logic             cbm_ack_in,
  input  wire logic [31:0]      cbm_rdata_in,
  input  wire logic             cbs_req_in,
  input  wire logic [31:0]      cbs_addr_in,
  input  wire logic [1:0]       cbs_space_in,
  input  wire logic [1:0]       cbs_size_in,
  input  wire logic             cbs_write_in,
  input  wire logic [31:0]      cbs_wdata_in,
  output logic                  cbs_ack_out,
  output logic      [31:0]      cbs_rdata_out,
  input  wire logic [3:0]       win_en_in,
  input  wire logic [3:0]       win_out_in,
  input  wire logic [3:0][31:0] win_base_in,
  input  wire logic [3:0][31:0] win_mask_in,
  input  wire logic [6:0]       bp_irq_n_in,
  output logic      [6:0]       bp_irq_n_out,
  output logic      [6:0]       bp_irq_oe_out,
  input  wire logic [6:0]       lk_irq_n_in,
  output logic      [6:0]       lk_irq_n_out,
  output logic      [6:0]       lk_irq_oe_out,
  input  wire logic [7:0]       bp_trig_n_in,
  output logic      [7:0]       bp_trig_n_out,
  output logic      [7:0]       bp_trig_oe_out,
  input  wire logic [7:0]       lk_trig_n_in,
  output logic      [7:0]       lk_trig_n_out,
  output logic      [7:0]       lk_trig_oe_out,
  input  wire logic [2:0]       bp_sys_n_in,
  output logic      [2:0]       bp_sys_n_out,
  output logic      [2:0]       bp_sys_oe_out,
  input  wire logic [2:0]       lk_sys_n_in,
  output logic      [2:0]       lk_sys_n_out,
  output logic      [2:0]       lk_sys_oe_out,
  input  wire logic             bp_clk10_in,
  output logic                  bp_clk10_out,
  output logic                  bp_clk10_oe_out,
  input  wire logic             lk_clk10_in,
  output logic                  lk_clk10_out,
  output logic                  lk_clk10_oe_out,
  input  wire logic [2:0]       clk_sw_in
);
  typedef enum logic [2:0] {B_IDLE, B_PUSH, B_WAIT, B_DROP} bwb_bstate_type;
  typedef enum logic [1:0] {C_IDLE, C_OWN, C_XFER} bwb_cstate_type;
  typedef enum logic [1:0] {I_IDLE, I_OWN, I_XFER, I_DROP} bwb_istate_type;

  typedef struct packed {
    bwb_bstate_type                 bst;
    bwb_cstate_type                 cst;
    bwb_istate_type                 ist;
    logic                           xfer_done;
    logic                           bp_ack;
    logic [31:0]                    bp_rdata;
    logic [31:0]                    fwd_rdata;
    logic                           cb_own_req;
    logic                           cbm_req;
    logic [bwb_pkg::REQ_W-1:0]      cbm_word;
    logic                           bp_own_req;
    logic                           bpm_req;
    logic [bwb_pkg::REQ_W-1:0]      bpm_word;
    logic                           cbs_ack;
    logic [31:0]                    cbs_rdata;
    logic [15:0]                    irq_cfg;
    logic [15:0]                    trig_cfg;
    logic [15:0]                    sys_cfg;
    logic [6:0]                     bp_irq_oe;
    logic [6:0]                     lk_irq_oe;
    logic [7:0]                     bp_trig_oe;
    logic [7:0]                     lk_trig_oe;
    logic [2:0]                     bp_sys_oe;
    logic [2:0]                     lk_sys_oe;
    logic                           clk_to_bp;
    logic                           clk_to_lk;
    logic                           clk_bp_oe;
    logic                           clk_lk_oe;
  } bwb_state_type;

  bwb_state_type s, next_s;

  // lines that a config register routes toward one side: enabled, direction, source active
  function automatic logic [7:0] bwb_drive(input logic [7:0] en, input logic [7:0] dir,
                                           input logic [7:0] src_n);
    return en & dir & ~src_n;
  endfunction : bwb_drive

  function automatic logic [2:0] bwb_level(input logic [31:0] addr);
    return addr[3:1];
  endfunction : bwb_level

  logic [3:0]                bp_hit, cb_hit;
  logic                      own_hit, fwd_hit, claim_hit, fwd_iack, claim_iack;
  logic [2:0]                bp_lvl, cb_lvl;
  logic [7:0]                irq_en, irq_dir;
  logic [bwb_pkg::REQ_W-1:0] bp_word, fifo_head;
  logic                      fifo_in_ready, fifo_out_valid, fifo_pop;

  bwb_window_decode u_bp_dec (
    .addr_in     (bp_addr_in),
    .space_in    (bp_space_in),
    .win_en_in   (win_en_in),
    .win_base_in (win_base_in),
    .win_mask_in (win_mask_in),
    .hit_out     (bp_hit)
  );

  bwb_window_decode u_cb_dec (
    .addr_in     (cbs_addr_in),
    .space_in    (cbs_space_in),
    .win_en_in   (win_en_in),
    .win_base_in (win_base_in),
    .win_mask_in (win_mask_in),
    .hit_out     (cb_hit)
  );

  assign irq_en  = {1'b0, s.irq_cfg[bwb_pkg::NUM_IRQ-1:0]};
  assign irq_dir = {1'b0, s.irq_cfg[bwb_pkg::ROUTE_DIR_LSB +: bwb_pkg::NUM_IRQ]};
  assign bp_lvl  = bwb_level(bp_addr_in);
  assign cb_lvl  = bwb_level(cbs_addr_in);

  // our own routing registers in our slot of the configuration block, served locally
  assign own_hit = (bp_space_in == bwb_pkg::SPACE_A16) &&
                   (bp_addr_in[15:14] == bwb_pkg::CFG_TOP_BITS) &&
                   (bp_addr_in[13:6] == LOG_ADDR);

  // acknowledge of a level we drive from the link goes out on the cable
  assign fwd_iack = (bp_space_in == bwb_pkg::SPACE_IACK) && (bp_lvl != 3'h0) &&
                    irq_en[bp_lvl - 3'h1] && !irq_dir[bp_lvl - 3'h1] &&
                    !lk_irq_n_in[bp_lvl - 3'h1];
  // acknowledge from the cable for a level we send out is reissued here
  assign claim_iack = (cbs_space_in == bwb_pkg::SPACE_IACK) && (cb_lvl != 3'h0) &&
                      irq_en[cb_lvl - 3'h1] && irq_dir[cb_lvl - 3'h1] &&
                      !bp_irq_n_in[cb_lvl - 3'h1];

  assign fwd_hit   = !own_hit && (|(bp_hit & win_out_in) || fwd_iack);
  assign claim_hit = |(cb_hit & ~win_out_in) || claim_iack;

  assign bp_word  = {bp_addr_in, bp_space_in, bp_size_in, bp_write_in, bp_wdata_in};
  assign fifo_pop = (s.cst == C_OWN) && cb_own_grant_in;

  // one cycle at a time is in flight, the fifo decouples the backplane and cable engines on one clock
  bwb_fifo #(
    .WIDTH (bwb_pkg::REQ_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in    (sys_clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (s.bst == B_PUSH),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (bp_word),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_head)
  );

  always_comb begin
    next_s = s;
    next_s.bp_ack  = 1'b0;
    next_s.cbs_ack = 1'b0;
    // local backplane side
    case (s.bst)
      B_IDLE: begin
        if (bp_req_in && own_hit) begin
          next_s.bp_ack = 1'b1;
          next_s.bst = B_DROP;
          next_s.bp_rdata = 32'h0;
          if (bp_write_in) begin
            if (bp_addr_in[5:0] == bwb_pkg::REG_IRQ_OFS) begin
              next_s.irq_cfg = bp_wdata_in[15:0];
            end else if (bp_addr_in[5:0] == bwb_pkg::REG_TRIG_OFS) begin
              next_s.trig_cfg = bp_wdata_in[15:0];
            end else if (bp_addr_in[5:0] == bwb_pkg::REG_SYS_OFS) begin
              next_s.sys_cfg = bp_wdata_in[15:0];
            end
          end else if (bp_addr_in[5:0] == bwb_pkg::REG_IRQ_OFS) begin
            next_s.bp_rdata = {16'h0, s.irq_cfg};
          end else if (bp_addr_in[5:0] == bwb_pkg::REG_TRIG_OFS) begin
            next_s.bp_rdata = {16'h0, s.trig_cfg};
          end else if (bp_addr_in[5:0] == bwb_pkg::REG_SYS_OFS) begin
            next_s.bp_rdata = {16'h0, s.sys_cfg};
          end
        end else if (bp_req_in && fwd_hit) begin
          next_s.bst = B_PUSH;
        end
        // anything else is left alone for a bus timer to finish
      end
      B_PUSH: begin
        if (fifo_in_ready) begin
          next_s.bst = B_WAIT;
        end
      end
      B_WAIT: begin
        // the local requester is held until the far end has answered
        if (s.xfer_done) begin
          next_s.xfer_done = 1'b0;
          next_s.bp_ack = 1'b1;
          next_s.bp_rdata = s.fwd_rdata;
          next_s.bst = B_DROP;
        end
      end
      default: begin
        if (!bp_req_in) begin
          next_s.bst = B_IDLE;
        end
      end
    endcase
    // cable master engine, placed after the clear so a fresh completion wins
    case (s.cst)
      C_IDLE: begin
        if (fifo_out_valid) begin
          next_s.cb_own_req = 1'b1;
          next_s.cst = C_OWN;
        end
      end
      C_OWN: begin
        if (cb_own_grant_in) begin
          next_s.cbm_word = fifo_head;
          next_s.cbm_req = 1'b1;
          next_s.cst = C_XFER;
        end
      end
      default: begin
        if (cbm_ack_in) begin
          next_s.cbm_req = 1'b0;
          next_s.cb_own_req = 1'b0;
          next_s.fwd_rdata = cbm_rdata_in;
          next_s.xfer_done = 1'b1;
          next_s.cst = C_IDLE;
        end
      end
    endcase
    // inbound: claimed cable cycle replayed as backplane master
    case (s.ist)
      I_IDLE: begin
        if (cbs_req_in && claim_hit) begin
          next_s.bpm_word = {cbs_addr_in, cbs_space_in, cbs_size_in, cbs_write_in,
                             cbs_wdata_in};
          next_s.bp_own_req = 1'b1;
          next_s.ist = I_OWN;
        end
      end
      I_OWN: begin
        if (bp_own_grant_in) begin
          next_s.bpm_req = 1'b1;
          next_s.ist = I_XFER;
        end
      end
      I_XFER: begin
        if (bpm_ack_in) begin
          next_s.bpm_req = 1'b0;
          next_s.bp_own_req = 1'b0;
          next_s.cbs_ack = 1'b1;
          next_s.cbs_rdata = bpm_rdata_in;
          next_s.ist = I_DROP;
        end
      end
      default: begin
        if (!cbs_req_in) begin
          next_s.ist = I_IDLE;
        end
      end
    endcase
    // signal extension link routing, one cycle of latency on every line
    next_s.lk_irq_oe = 7'(bwb_drive(irq_en, irq_dir, {1'b1, bp_irq_n_in}));
    next_s.bp_irq_oe = 7'(bwb_drive(irq_en, ~irq_dir, {1'b1, lk_irq_n_in}));
    next_s.lk_trig_oe = bwb_drive(s.trig_cfg[7:0], s.trig_cfg[15:8], bp_trig_n_in);
    next_s.bp_trig_oe = bwb_drive(s.trig_cfg[7:0], ~s.trig_cfg[15:8], lk_trig_n_in);
    next_s.lk_sys_oe = 3'(bwb_drive({5'h0, s.sys_cfg[2:0]}, {5'h0, s.sys_cfg[10:8]},
                                    {5'h1F, bp_sys_n_in}));
    next_s.bp_sys_oe = 3'(bwb_drive({5'h0, s.sys_cfg[2:0]}, ~{5'h0, s.sys_cfg[10:8]},
                                    {5'h1F, lk_sys_n_in}));
    next_s.clk_to_lk = bp_clk10_in;
    next_s.clk_to_bp = lk_clk10_in;
    next_s.clk_lk_oe = (clk_sw_in == bwb_pkg::CLK_SW_OUT);
    next_s.clk_bp_oe = (clk_sw_in == bwb_pkg::CLK_SW_IN);
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '{bst: B_IDLE, cst: C_IDLE, ist: I_IDLE, irq_cfg: bwb_pkg::IRQ_CFG_RST,
             trig_cfg: bwb_pkg::TRIG_CFG_RST, sys_cfg: bwb_pkg::SYS_CFG_RST, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign bp_ack_out      = s.bp_ack;
  assign bp_rdata_out    = s.bp_rdata;
  assign bp_own_req_out  = s.bp_own_req;
  assign bpm_req_out     = s.bpm_req;
  assign {bpm_addr_out, bpm_space_out, bpm_size_out, bpm_write_out, bpm_wdata_out} = s.bpm_word;
  assign cb_own_req_out  = s.cb_own_req;
  assign cbm_req_out     = s.cbm_req;
  assign {cbm_addr_out, cbm_space_out, cbm_size_out, cbm_write_out, cbm_wdata_out} = s.cbm_word;
  assign cbs_ack_out     = s.cbs_ack;
  assign cbs_rdata_out   = s.cbs_rdata;
  assign bp_irq_n_out    = '0;
  assign bp_irq_oe_out   = s.bp_irq_oe;
  assign lk_irq_n_out    = '0;
  assign lk_irq_oe_out   = s.lk_irq_oe;
  assign bp_trig_n_out   = '0;
  assign bp_trig_oe_out  = s.bp_trig_oe;
  assign lk_trig_n_out   = '0;
  assign lk_trig_oe_out  = s.lk_trig_oe;
  assign bp_sys_n_out    = '0;
  assign bp_sys_oe_out   = s.bp_sys_oe;
  assign lk_sys_n_out    = '0;
  assign lk_sys_oe_out   = s.lk_sys_oe;
  assign bp_clk10_out    = s.clk_to_bp;
  assign bp_clk10_oe_out = s.clk_bp_oe;
  assign lk_clk10_out    = s.clk_to_lk;
  assign lk_clk10_oe_out = s.clk_lk_oe;

  default clocking cb_main @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_cable_owned;
    cb_own_req_out && cb_own_grant_in && (s.cst == C_OWN);
  endsequence
  sequence s_cable_answered;
    cbm_req_out && cbm_ack_in;
  endsequence

  a_cfg_window_top: assert property (bp_hit[bwb_pkg::WIN_CFG] |->
      bp_space_in == bwb_pkg::SPACE_A16 && bp_addr_in[15:14] == 2'h3)
    else $error("config window hit outside top of short space");
  a_fwd_pushes: assert property (s.bst == B_IDLE && bp_req_in && fwd_hit |=>
      s.bst == B_PUSH ##[1:17] s.bst == B_WAIT)
    else $error("mapped-out cycle not queued for the cable");
  a_unmapped_ignored: assert property (s.bst == B_IDLE && bp_req_in && !fwd_hit && !own_hit
      |=> s.bst == B_IDLE && !bp_ack_out)
    else $error("unmapped cycle was taken");
  a_claim_inbound: assert property (s.ist == I_IDLE && cbs_req_in && claim_hit |=>
      bp_own_req_out && !bpm_req_out)
    else $error("mapped-in cable cycle not claimed");
  a_local_fast: assert property (s.bst == B_IDLE && bp_req_in && own_hit |=>
      bp_ack_out && !cb_own_req_out [*1])
    else $error("local register access not answered next cycle");
  a_own_first: assert property ($rose(bpm_req_out) |-> $past(bp_own_grant_in, 1))
    else $error("backplane transfer began without ownership");
  a_cable_xfer: assert property (s_cable_owned |=> cbm_req_out && cb_own_req_out)
    else $error("cable transfer did not follow ownership");
  a_interlock_hold: assert property (bpm_req_out && !bpm_ack_in |=> bpm_req_out)
    else $error("backplane request dropped before answer");
  a_fwd_done_ack: assert property (s_cable_answered ##1 s.bst == B_WAIT |=> bp_ack_out)
    else $error("local requester not released after cable answer");
  a_irq_route_out: assert property (irq_en[0] && irq_dir[0] && !bp_irq_n_in[0] |=>
      lk_irq_oe_out[0])
    else $error("outward interrupt not driven on link");
endmodule : bwb_bridge
`default_nettype wire

/* verification/bwb_far_end.sv */
// bwb_far_end: remote cable bus target and cable ownership arbiter
// assumes cable master fields stay held with cbm_req_out until the ack pulse
`default_nettype none
module bwb_far_end (
  input  wire logic        sys_clk_in,
  input  wire logic        cb_own_req_out,
  input  wire logic        cbm_req_out,
  input  wire logic [31:0] cbm_addr_out,
  input  wire logic [3:0]  slow_in,
  output logic             cb_own_grant_in,
  output logic             cbm_ack_in,
  output logic      [31:0] cbm_rdata_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_cnt = 0;
  initial begin
    cb_own_grant_in = 1'b0;
    cbm_ack_in = 1'b0;
    cbm_rdata_in = 32'h0000_0000;
  end
  always @(posedge sys_clk_in) begin
    cb_own_grant_in <= cb_own_req_out;
    cbm_ack_in <= 1'b0;
    // released data toggles so a stale value never passes for an answer
    cbm_rdata_in <= ~cbm_rdata_in;
    if (cbm_req_out && !cbm_ack_in && cb_own_grant_in) begin
      if (wait_cnt == slow_in) begin
        cbm_ack_in <= 1'b1;
        cbm_rdata_in <= ~cbm_addr_out;
        wait_cnt <= 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule : bwb_far_end
`default_nettype wire

/* verification/tb.sv */
// tb: self-checking bench for bwb_bridge: routing registers, forwarding, refusal
// assumes bwb_far_end on the cable side and a one-cycle backplane target in this module
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin errors++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in = 0, rst_n_in = 0, bp_req_in = 0, bp_write_in = 0, bpm_ack_in = 0;
  logic cbs_req_in = 0, cbs_write_in = 0, bp_clk10_in = 0, lk_clk10_in = 0;
  logic [31:0] bp_addr_in = 0, bp_wdata_in = 0, bpm_rdata_in = 0, cbs_addr_in = 0;
  logic [31:0] cbs_wdata_in = 0, seed = 32'h0000_DB76, adr = 0;
  logic [1:0] bp_space_in = 0, bp_size_in = 0, cbs_space_in = 0, cbs_size_in = 0;
  logic [3:0] win_en_in = 4'h6, win_out_in = 4'h2, slow_in = 0;
  logic [3:0][31:0] win_base_in = {4{32'h0020_0000}}, win_mask_in = {4{32'h00F0_0000}};
  logic [6:0] bp_irq_n_in = '1, lk_irq_n_in = '1;
  logic [7:0] bp_trig_n_in = '1, lk_trig_n_in = '1;
  logic [2:0] bp_sys_n_in = '1, lk_sys_n_in = '1, clk_sw_in = 0;
  wire logic bp_own_grant_in;
  logic bp_ack_out, bp_own_req_out, bpm_req_out, bpm_write_out, cb_own_req_out, cbm_req_out;
  logic cbm_write_out, cbs_ack_out, bp_clk10_out, bp_clk10_oe_out, lk_clk10_out;
  logic lk_clk10_oe_out, cb_own_grant_in, cbm_ack_in;
  logic [31:0] bp_rdata_out, bpm_addr_out, bpm_wdata_out, cbm_addr_out, cbm_wdata_out;
  logic [31:0] cbs_rdata_out, cbm_rdata_in;
  logic [1:0] bpm_space_out, bpm_size_out, cbm_space_out, cbm_size_out;
  logic [6:0] bp_irq_n_out, bp_irq_oe_out, lk_irq_n_out, lk_irq_oe_out;
  logic [7:0] bp_trig_n_out, bp_trig_oe_out, lk_trig_n_out, lk_trig_oe_out;
  logic [2:0] bp_sys_n_out, bp_sys_oe_out, lk_sys_n_out, lk_sys_oe_out;
  logic [32:0] expq[$], exp_word;
  int errors = 0, checks_done = 0;
  assign bp_own_grant_in = bp_own_req_out;
  bwb_bridge dut (.*);
  bwb_far_end far (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // one backplane cycle; the request is held until the ack pulse or a bounded wait
  task automatic cyc(input logic [31:0] a, input logic [1:0] sp, input logic w,
                     input logic [31:0] d);
    @(negedge sys_clk_in);
    bp_addr_in = a;
    bp_space_in = sp;
    bp_size_in = (sp == bwb_pkg::SPACE_A16) ? bwb_pkg::SIZE_D16 : bwb_pkg::SIZE_D32;
    bp_write_in = w;
    bp_wdata_in = d;
    bp_req_in = 1'b1;
    for (int n = 0; n < 40 && bp_ack_out !== 1'b1; n++) @(negedge sys_clk_in);
    bp_req_in = 1'b0;
    @(negedge sys_clk_in);
  endtask : cyc
  // one cable cycle toward this mainframe, held like cyc
  task automatic icyc(input logic [31:0] a, input logic [1:0] sp);
    @(negedge sys_clk_in);
    cbs_addr_in = a;
    cbs_space_in = sp;
    cbs_req_in = 1'b1;
    for (int n = 0; n < 40 && cbs_ack_out !== 1'b1; n++) @(negedge sys_clk_in);
    cbs_req_in = 1'b0;
    @(negedge sys_clk_in);
  endtask : icyc
  // backplane target: answers one cycle after the request, data marks address and space
  always @(posedge sys_clk_in) begin
    bpm_ack_in <= bpm_req_out && !bpm_ack_in;
    bpm_rdata_in <= ~bpm_addr_out ^ {30'h0, bpm_space_out};
  end
  // acks are sampled mid-cycle, where the registered pulse has settled
  always @(negedge sys_clk_in) if (bp_ack_out === 1'b1 || cbs_ack_out === 1'b1) begin
    if (expq.size() == 0) `CHK("unrequested ack", 1'b0, 1'b1)
    else begin
      exp_word = expq.pop_front();
      if (exp_word[32])
        `CHK("read data", exp_word[31:0], bp_ack_out ? bp_rdata_out : cbs_rdata_out)
    end
  end
  initial forever #5 sys_clk_in = ~sys_clk_in;
  initial begin
    #200us;
    errors++;
    conclude();
  end
  initial begin
    repeat (20) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    expq.push_back(33'h0);
    cyc(32'h0000_C060, bwb_pkg::SPACE_A16, 1'b1, 32'h0000_0103);
    expq.push_back({1'b1, 32'h0000_0103});
    cyc(32'h0000_C060, bwb_pkg::SPACE_A16, 1'b0, 32'h0);
    bp_irq_n_in[0] = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    `CHK("irq route", 14'h0001, {bp_irq_oe_out, lk_irq_oe_out})
    expq.push_back(33'h0);
    cyc(32'h0000_C062, bwb_pkg::SPACE_A16, 1'b1, 32'h0000_0080);
    lk_trig_n_in[7] = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    `CHK("trigger route", 16'h8000, {bp_trig_oe_out, lk_trig_oe_out})
    expq.push_back(33'h0);
    cyc(32'h0000_C064, bwb_pkg::SPACE_A16, 1'b1, 32'h0000_0101);
    bp_sys_n_in[0] = 1'b0;
    bp_clk10_in = 1'b1;
    clk_sw_in = bwb_pkg::CLK_SW_OUT;
    repeat (3) @(negedge sys_clk_in);
    `CHK("sys route", 6'h01, {bp_sys_oe_out, lk_sys_oe_out})
    `CHK("clock route", 3'h3, {bp_clk10_oe_out, lk_clk10_oe_out, lk_clk10_out})
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      slow_in = {2'h0, seed[5:4]};
      adr = 32'h0020_0000 | (seed & 32'h000F_FFFC);
      expq.push_back({1'b1, ~adr});
      cyc(adr, bwb_pkg::SPACE_A24, 1'b0, 32'h0);
      expq.push_back({1'b1, ~adr ^ {30'h0, bwb_pkg::SPACE_A32}});
      icyc(adr, bwb_pkg::SPACE_A32);
    end
    lk_irq_n_in[1] = 1'b0;
    expq.push_back({1'b1, ~32'h0000_0004});
    cyc(32'h0000_0004, bwb_pkg::SPACE_IACK, 1'b0, 32'h0);
    expq.push_back({1'b1, ~32'h0000_0002 ^ {30'h0, bwb_pkg::SPACE_IACK}});
    icyc(32'h0000_0002, bwb_pkg::SPACE_IACK);
    icyc(32'h0020_0000, bwb_pkg::SPACE_A24);
    cyc(32'h0050_0000, bwb_pkg::SPACE_A24, 1'b0, 32'h0);
    `CHK("cable idle", 1'b0, cb_own_req_out)
    `CHK("all answered", 0, expq.size())
    conclude();
  end
endmodule : tb
`default_nettype wire
